// File: pkg/dsr_pkg.sv
// ----------------------------------------------------------------
// bank switched dual port memory constants
// ----------------------------------------------------------------
package dsr_pkg;
	localparam int PORTS = 2;
	localparam int BANK_W = 6;
	localparam int WORD_W = 12;
	localparam int ADDR_W = BANK_W + WORD_W;
	localparam int NUM_BANKS = 64;
	localparam int WORDS_PER_BANK = 4096;
	localparam int DEPTH = NUM_BANKS * WORDS_PER_BANK;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	// bank field sits on top of the in-bank word address
	localparam int BANK_LSB = WORD_W;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h00001;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
	localparam logic [LANES-1:0] LANES_OFF = 4'h0;
endpackage

// File: pkg/dsr_port_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// registered access command from one port front end to the core
// ----------------------------------------------------------------
interface dsr_port_if;
	logic [dsr_pkg::ADDR_W-1:0] addr;
	logic en;
	logic rd;
	logic wr;
	logic [dsr_pkg::LANES-1:0] lanes;
	logic [dsr_pkg::DATA_W-1:0] wdata;
	logic pipe;
	modport ctl (output addr, en, rd, wr, lanes, wdata, pipe);
	modport core (input addr, en, rd, wr, lanes, wdata, pipe);
endinterface
`default_nettype wire

// File: logic/dsr_port.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_port (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic chip_sel_low_active_n,
	input wire logic chip_sel_high_active,
	input wire logic rw,
	input wire logic [dsr_pkg::LANES-1:0] byte_lane_sel_n,
	input wire logic addr_strobe_load_n,
	input wire logic counter_advance_n,
	input wire logic counter_reload_n,
	input wire logic [dsr_pkg::BANK_W-1:0] bank_select,
	input wire logic [dsr_pkg::WORD_W-1:0] word_addr,
	input wire logic [dsr_pkg::DATA_W-1:0] data_in,
	input wire logic output_stage_select,
	dsr_port_if.ctl pif
);
	logic [dsr_pkg::ADDR_W-1:0] ext_addr;
	logic [dsr_pkg::ADDR_W-1:0] addr_ff;
	logic [dsr_pkg::ADDR_W-1:0] load_ff;
	logic [dsr_pkg::ADDR_W-1:0] nxt_addr;
	logic en_ff;
	logic rd_ff;
	logic wr_ff;
	logic pipe_ff;
	logic [dsr_pkg::LANES-1:0] lanes_ff;
	logic [dsr_pkg::DATA_W-1:0] wdata_ff;

	// ------------------------------------------------------------
	// address counter
	// ------------------------------------------------------------
	// counter covers bank and word together so bursts cross banks
	assign ext_addr = {bank_select, word_addr};

	// next internal address: load, reload, advance or hold
	always_comb begin
		if (!addr_strobe_load_n) begin
			nxt_addr = ext_addr;
		end else if (!counter_reload_n) begin
			nxt_addr = load_ff;
		end else if (!counter_advance_n) begin
			nxt_addr = addr_ff + dsr_pkg::ADDR_STEP;
		end else begin
			nxt_addr = addr_ff;
		end
	end

	// internal address register, used by the access of the next cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= dsr_pkg::ADDR_RST;
		end else if (ce) begin
			addr_ff <= nxt_addr;
		end
	end

	// last strobe-loaded address, target of a reload
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_ff <= dsr_pkg::ADDR_RST;
		end else if (ce && !addr_strobe_load_n) begin
			load_ff <= ext_addr;
		end
	end

	// ------------------------------------------------------------
	// registered controls and write data
	// ------------------------------------------------------------
	// either chip select off for one cycle powers the port down
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_ff <= 1'b0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			lanes_ff <= dsr_pkg::LANES_OFF;
			wdata_ff <= dsr_pkg::DATA_RST;
		end else if (ce) begin
			en_ff <= !chip_sel_low_active_n && chip_sel_high_active;
			rd_ff <= rw;
			wr_ff <= !rw;
			lanes_ff <= ~byte_lane_sel_n;
			wdata_ff <= data_in;
		end
	end

	// output stage strap, static, caught by a clocked stage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_ff <= 1'b0;
		end else if (ce) begin
			pipe_ff <= output_stage_select;
		end
	end

	assign pif.addr = addr_ff;
	assign pif.en = en_ff;
	assign pif.rd = rd_ff;
	assign pif.wr = wr_ff;
	assign pif.lanes = lanes_ff;
	assign pif.wdata = wdata_ff;
	assign pif.pipe = pipe_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	strobe_load_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(ce && !addr_strobe_load_n) |=> addr_ff == $past(ext_addr))
		else $error("strobe did not load the external address");

	advance_wrap_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(ce && addr_strobe_load_n && counter_reload_n && !counter_advance_n
		&& addr_ff == 18'h3ffff) |=> addr_ff == 18'h00000)
		else $error("counter did not wrap from the last bank to bank 0");

	advance_step_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(ce && addr_strobe_load_n && counter_reload_n && !counter_advance_n)
		|=> addr_ff == 18'($past(addr_ff) + 18'h00001))
		else $error("counter advance did not step by one");

	hold_addr_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(addr_strobe_load_n && counter_reload_n && counter_advance_n)
		|=> $stable(addr_ff))
		else $error("address moved with no load or advance");

	reload_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(ce && !addr_strobe_load_n) ##1 (ce && addr_strobe_load_n
		&& !counter_reload_n) |=> addr_ff == $past(ext_addr, 2))
		else $error("reload missed the last loaded address");

	powerdown_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(ce && (chip_sel_low_active_n || !chip_sel_high_active)) |=> !en_ff)
		else $error("port stayed enabled with a chip select off");
endmodule
`default_nettype wire

// File: logic/dsr_bank_sram.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 64 banks of 4K 36-bit words
// - same bank both ports: both accesses invalid
// - chip select off powers that port down
// - flow-through read data valid two cycles after select
// - strobe low loads the external address
// - strobe low: external address, else counter
// - advance steps address; write uses new one
// - no load, advance or reload: address holds
// - counter spans banks, wraps bank 63 to 0
// - reload returns to last loaded address
// - pipelined output one cycle after flow-through
// - output state set by previous-cycle controls
// - write readable by other port next cycle
// - output enable acts on drivers asynchronously
// - deselected byte lane reads as high impedance
// - strap picks pipelined high, flow-through low
module dsr_bank_sram (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic chip_sel_low_active_n_l,
	input wire logic chip_sel_high_active_l,
	input wire logic rw_l,
	input wire logic [dsr_pkg::LANES-1:0] byte_lane_sel_n_l,
	input wire logic addr_strobe_load_n_l,
	input wire logic counter_advance_n_l,
	input wire logic counter_reload_n_l,
	input wire logic [dsr_pkg::BANK_W-1:0] bank_select_l,
	input wire logic [dsr_pkg::WORD_W-1:0] word_addr_l,
	input wire logic [dsr_pkg::DATA_W-1:0] dq_in_l,
	output logic [dsr_pkg::DATA_W-1:0] dq_out_l,
	output logic [dsr_pkg::LANES-1:0] dq_oe_l,
	input wire logic output_en_n_l,
	input wire logic output_stage_select_l,
	output logic bank_conflict_l,
	output logic powered_down_l,
	input wire logic chip_sel_low_active_n_r,
	input wire logic chip_sel_high_active_r,
	input wire logic rw_r,
	input wire logic [dsr_pkg::LANES-1:0] byte_lane_sel_n_r,
	input wire logic addr_strobe_load_n_r,
	input wire logic counter_advance_n_r,
	input wire logic counter_reload_n_r,
	input wire logic [dsr_pkg::BANK_W-1:0] bank_select_r,
	input wire logic [dsr_pkg::WORD_W-1:0] word_addr_r,
	input wire logic [dsr_pkg::DATA_W-1:0] dq_in_r,
	output logic [dsr_pkg::DATA_W-1:0] dq_out_r,
	output logic [dsr_pkg::LANES-1:0] dq_oe_r,
	input wire logic output_en_n_r,
	input wire logic output_stage_select_r,
	output logic bank_conflict_r,
	output logic powered_down_r
);
	localparam int P = dsr_pkg::PORTS;
	localparam int AW = dsr_pkg::ADDR_W;
	localparam int DW = dsr_pkg::DATA_W;
	localparam int LN = dsr_pkg::LANES;
	localparam int BW = dsr_pkg::BANK_W;
	localparam int WW = dsr_pkg::WORD_W;

	logic rst_meta_ff;
	logic rst_sync_ff;
	logic rst_sync_n;
	logic [P-1:0] cs0_n;
	logic [P-1:0] cs1;
	logic [P-1:0] rw_in;
	logic [P-1:0] ads_n;
	logic [P-1:0] adv_n;
	logic [P-1:0] rld_n;
	logic [P-1:0] strap;
	logic [P-1:0] oe_n;
	logic [LN-1:0] be_n [P];
	logic [BW-1:0] bank_in [P];
	logic [WW-1:0] word_in [P];
	logic [DW-1:0] din [P];
	logic [AW-1:0] addr_w [P];
	logic [LN-1:0] lanes_w [P];
	logic [DW-1:0] wdata_w [P];
	logic [P-1:0] en_w;
	logic [P-1:0] pipe_w;
	logic [P-1:0] conflict;
	logic [P-1:0] go_rd;
	logic [P-1:0] go_wr;
	logic [DW-1:0] st_data_ff [P];
	logic [LN-1:0] st_lanes_ff [P];
	logic [DW-1:0] dout_ff [P];
	logic [LN-1:0] drv_ff [P];
	logic [P-1:0] conf_ff;
	logic [P-1:0] pd_ff;
	logic [LN-1:0] dq_oe_w [P];
	// shared storage, one flat array addressed by bank and word
	logic [DW-1:0] mem [dsr_pkg::DEPTH];

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	// two stage release so every register on rst_sync_n leaves reset together
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_sync_n = rst_sync_ff;

	// ------------------------------------------------------------
	// pin gathering, index 0 left and 1 right
	// ------------------------------------------------------------
	assign cs0_n = {chip_sel_low_active_n_r, chip_sel_low_active_n_l};
	assign cs1 = {chip_sel_high_active_r, chip_sel_high_active_l};
	assign rw_in = {rw_r, rw_l};
	assign ads_n = {addr_strobe_load_n_r, addr_strobe_load_n_l};
	assign adv_n = {counter_advance_n_r, counter_advance_n_l};
	assign rld_n = {counter_reload_n_r, counter_reload_n_l};
	assign strap = {output_stage_select_r, output_stage_select_l};
	assign oe_n = {output_en_n_r, output_en_n_l};
	assign be_n[0] = byte_lane_sel_n_l;
	assign be_n[1] = byte_lane_sel_n_r;
	assign bank_in[0] = bank_select_l;
	assign bank_in[1] = bank_select_r;
	assign word_in[0] = word_addr_l;
	assign word_in[1] = word_addr_r;
	assign din[0] = dq_in_l;
	assign din[1] = dq_in_r;

	dsr_port_if pif [P] ();

	// ------------------------------------------------------------
	// bank arbitration
	// ------------------------------------------------------------
	// bank field of an internal address, shared by both ports
	function automatic logic [BW-1:0] bank_of(input logic [AW-1:0] a);
		return a[AW-1:dsr_pkg::BANK_LSB];
	endfunction

	// both ports in one bank: neither access is carried out
	assign conflict[0] = en_w[0] && en_w[1]
		&& bank_of(addr_w[0])
		== bank_of(addr_w[1]);
	assign conflict[1] = conflict[0];

	// ------------------------------------------------------------
	// memory write, both ports, byte lanes
	// ------------------------------------------------------------
	// single process keeps one driver on the shared array
	// a voided conflict write never reaches the array
	always_ff @(posedge core_clk) begin
		if (ce) begin
			for (int p = 0; p < P; p++) begin
				for (int b = 0; b < LN; b++) begin
					if (go_wr[p] && lanes_w[p][b]) begin
						mem[addr_w[p]][b*dsr_pkg::LANE_W +: dsr_pkg::LANE_W]
							<= wdata_w[p][b*dsr_pkg::LANE_W +: dsr_pkg::LANE_W];
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// per port front end and read path
	// ------------------------------------------------------------
	for (genvar g = 0; g < P; g++) begin : g_port
		localparam int H = 1 - g;

		dsr_port u_port (
			.core_clk(core_clk),
			.rst_n(rst_sync_n),
			.ce(ce),
			.chip_sel_low_active_n(cs0_n[g]),
			.chip_sel_high_active(cs1[g]),
			.rw(rw_in[g]),
			.byte_lane_sel_n(be_n[g]),
			.addr_strobe_load_n(ads_n[g]),
			.counter_advance_n(adv_n[g]),
			.counter_reload_n(rld_n[g]),
			.bank_select(bank_in[g]),
			.word_addr(word_in[g]),
			.data_in(din[g]),
			.output_stage_select(strap[g]),
			.pif(pif[g])
		);

		assign addr_w[g] = pif[g].addr;
		assign lanes_w[g] = pif[g].lanes;
		assign wdata_w[g] = pif[g].wdata;
		assign en_w[g] = pif[g].en;
		assign pipe_w[g] = pif[g].pipe;
		assign go_rd[g] = pif[g].en && pif[g].rd && !conflict[g];
		assign go_wr[g] = pif[g].en && pif[g].wr && !conflict[g];

		// extra stage used only in pipelined mode
		always_ff @(posedge core_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				st_data_ff[g] <= dsr_pkg::DATA_RST;
				st_lanes_ff[g] <= dsr_pkg::LANES_OFF;
			end else if (ce) begin
				st_data_ff[g] <= mem[addr_w[g]];
				st_lanes_ff[g] <= go_rd[g] ? lanes_w[g] : dsr_pkg::LANES_OFF;
			end
		end

		// output register, lane drive set by last cycle's controls
		always_ff @(posedge core_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				dout_ff[g] <= dsr_pkg::DATA_RST;
				drv_ff[g] <= dsr_pkg::LANES_OFF;
			end else if (ce) begin
				if (pipe_w[g]) begin
					dout_ff[g] <= st_data_ff[g];
					drv_ff[g] <= st_lanes_ff[g];
				end else begin
					dout_ff[g] <= mem[addr_w[g]];
					drv_ff[g] <= go_rd[g] ? lanes_w[g] : dsr_pkg::LANES_OFF;
				end
			end
		end

		// status flags for the host
		// power down only gates access, the counter still runs
		always_ff @(posedge core_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				conf_ff[g] <= 1'b0;
				pd_ff[g] <= 1'b1;
			end else if (ce) begin
				conf_ff[g] <= conflict[g];
				pd_ff[g] <= !en_w[g];
			end
		end

		// output enable gates the drivers without waiting for a clock
		assign dq_oe_w[g] = oe_n[g] ? dsr_pkg::LANES_OFF : drv_ff[g];

		sequence rd_flow_s;
			ce && go_rd[g] && !pipe_w[g];
		endsequence
		sequence rd_pipe_s;
			(ce && go_rd[g] && pipe_w[g]) ##1 (ce && pipe_w[g]);
		endsequence
		sequence wr_then_rd_s;
			(ce && go_wr[g] && lanes_w[g] == 4'hf) ##1 (ce && go_rd[H]
			&& !pipe_w[H] && addr_w[H] == $past(addr_w[g]));
		endsequence

		flow_lanes_a: assert property (
			@(posedge core_clk) disable iff (!rst_sync_n)
			rd_flow_s |=> drv_ff[g] == $past(lanes_w[g]))
			else $error("flow-through drive not one cycle after read");

		pipe_lanes_a: assert property (
			@(posedge core_clk) disable iff (!rst_sync_n)
			rd_pipe_s |=> drv_ff[g] == $past(lanes_w[g], 2))
			else $error("pipelined drive not two cycles after read");

		conflict_a: assert property (
			@(posedge core_clk) disable iff (!rst_sync_n)
			(ce && conflict[g] && !pipe_w[g]) |=> conf_ff[g] && drv_ff[g] == 4'h0)
			else $error("same bank access was not voided");

		powerdown_drive_a: assert property (
			@(posedge core_clk) disable iff (!rst_sync_n)
			(ce && !en_w[g] && !pipe_w[g]) |=> pd_ff[g] && drv_ff[g] == 4'h0)
			else $error("powered down port still drives");

		oe_async_a: assert property (
			@(posedge core_clk) disable iff (!rst_sync_n)
			!oe_n[g] |-> dq_oe_w[g] == drv_ff[g])
			else $error("output enable does not pass lane drive");

		cross_port_a: assert property (
			@(posedge core_clk) disable iff (!rst_sync_n)
			wr_then_rd_s |=> dout_ff[H] == $past(wdata_w[g], 2))
			else $error("other port missed the word just written");
	end

	// ------------------------------------------------------------
	// top level outputs
	// ------------------------------------------------------------
	assign dq_out_l = dout_ff[0];
	assign dq_out_r = dout_ff[1];
	assign dq_oe_l = dq_oe_w[0];
	assign dq_oe_r = dq_oe_w[1];
	assign bank_conflict_l = conf_ff[0];
	assign bank_conflict_r = conf_ff[1];
	assign powered_down_l = pd_ff[0];
	assign powered_down_r = pd_ff[1];
endmodule
`default_nettype wire

// File: bench/dsr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host controller model for one port
// ----------------------------------------------------------------
module dsr_host (
	input wire logic core_clk,
	output logic [6:0] ctl,
	output logic [3:0] ln_n,
	output logic [17:0] addr,
	output logic [35:0] din
);
	// ctl is {cs_n, cs_h, rw, load_n, adv_n, reload_n, oe_n}
	initial begin
		ctl = 7'h7e;
		ln_n = 4'hf;
		addr = 18'h00000;
		din = 36'h000000000;
	end
	// drive one command, then let the next rising edge take it
	task op(input logic [1:0] cs, input logic r, input logic ld,
		input logic adv, input logic rel, input logic [3:0] ln,
		input logic [17:0] a, input logic [35:0] d);
		ctl[6:1] = {cs[0], cs[1], r, ld, adv, rel};
		ln_n = ln;
		addr = a;
		din = d;
		@(posedge core_clk);
		#1;
	endtask
	// deselected cycle: counter holds, released data toggles
	task idle();
		op(2'b11, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, addr, ~din);
	endtask
	// asynchronous output enable
	task oe(input logic v);
		ctl[0] = v;
	endtask
endmodule
`default_nettype wire

// File: bench/dsr_bank_sram_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_bank_sram_bench;
	localparam logic [17:0] adr_a = 18'h03010;
	localparam logic [17:0] adr_b = 18'h07020;
	localparam logic [35:0] d_one = 36'h123456789;
	localparam logic [35:0] d_two = 36'hfedcba987;
	localparam logic [35:0] d_thr = 36'h0c3c3c3c3;
	localparam logic [35:0] d_fou = 36'h53c53c53c;
	logic core_clk, rst_n, ce;
	logic [6:0] cl, cr;
	logic [3:0] ll, lr, el, er;
	logic [17:0] al, ar;
	logic [35:0] dl, dr, ql, qr;
	logic kl, kr, pl, pr;
	logic [1:0] offs [2] = '{2'b11, 2'b00};
	int fails = 0;
	int n_checks = 0;
	// ----------------------------------------------------------------
	// clock, hosts and memory
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	dsr_host hl (.core_clk(core_clk), .ctl(cl), .ln_n(ll), .addr(al),
		.din(dl));
	dsr_host hr (.core_clk(core_clk), .ctl(cr), .ln_n(lr), .addr(ar),
		.din(dr));
	dsr_bank_sram dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
		.chip_sel_low_active_n_l(cl[6]), .chip_sel_high_active_l(cl[5]),
		.rw_l(cl[4]), .byte_lane_sel_n_l(ll),
		.addr_strobe_load_n_l(cl[3]), .counter_advance_n_l(cl[2]),
		.counter_reload_n_l(cl[1]), .bank_select_l(al[17:12]),
		.word_addr_l(al[11:0]), .dq_in_l(dl), .dq_out_l(ql), .dq_oe_l(el),
		.output_en_n_l(cl[0]), .output_stage_select_l(1'b0),
		.bank_conflict_l(kl), .powered_down_l(pl),
		.chip_sel_low_active_n_r(cr[6]), .chip_sel_high_active_r(cr[5]),
		.rw_r(cr[4]), .byte_lane_sel_n_r(lr),
		.addr_strobe_load_n_r(cr[3]), .counter_advance_n_r(cr[2]),
		.counter_reload_n_r(cr[1]), .bank_select_r(ar[17:12]),
		.word_addr_r(ar[11:0]), .dq_in_r(dr), .dq_out_r(qr), .dq_oe_r(er),
		.output_en_n_r(cr[0]), .output_stage_select_r(1'b1),
		.bank_conflict_r(kr), .powered_down_r(pr)
	);
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [35:0] got,
		input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic ld, input logic adv, input logic [3:0] ln,
		input logic [17:0] a, input logic [35:0] d);
		hl.op(2'b10, 1'b0, ld, adv, 1'b1, ln, a, d);
	endtask
	// left port is flow-through: data two edges after the command
	task rd(input logic ld, input logic adv, input logic rel,
		input logic [3:0] ln, input logic [17:0] a, input logic [35:0] exp);
		logic [35:0] m;
		for (int b = 0; b < 4; b++) m[9*b +: 9] = {9{~ln[b]}};
		hl.op(2'b10, 1'b1, ld, adv, rel, ln, a, 36'h000000000);
		hl.idle();
		chk("left lanes", el, 4'(~ln));
		chk("left data", ql & m, exp & m);
	endtask
	// right port is pipelined: data three edges after the command
	task rdr(input logic [17:0] a, input logic [35:0] exp);
		hr.op(2'b10, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, a, 36'h000000000);
		hr.idle();
		chk("right early", er, 4'h0);
		chk("right awake", pr, 1'b0);
		hr.idle();
		chk("right lanes", er, 4'hf);
		chk("right data", qr, exp);
	endtask
	task done_t(input string nm);
		$display("test %s done", nm);
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		chk("reset power", pl, 1'b1);
		chk("reset drive", el, 4'h0);
		chk("reset clash", kr, 1'b0);
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		done_t("reset");
		wr(1'b0, 1'b1, 4'h0, adr_a, d_one);
		rd(1'b0, 1'b1, 1'b1, 4'h0, adr_a, d_one);
		chk("awake", pl, 1'b0);
		rdr(adr_a, d_one);
		done_t("basic");
		wr(1'b0, 1'b1, 4'h0, adr_b, d_two);
		fork
			hl.idle();
			rdr(adr_b, d_two);
		join
		wr(1'b0, 1'b1, 4'he, adr_b, 36'h000000000);
		rd(1'b0, 1'b1, 1'b1, 4'h5, adr_b, 36'hfedcba800);
		wr(1'b0, 1'b1, 4'h0, adr_b, 36'hfedcba800);
		fork
			hl.idle();
			hr.op(2'b10, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, adr_b, d_thr);
		join
		fork
			hr.idle();
			rd(1'b0, 1'b1, 1'b1, 4'h0, adr_b, d_thr);
		join
		done_t("lanes");
		hl.op(2'b10, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, adr_a, 36'h000000000);
		hl.idle();
		hl.oe(1'b1);
		#2;
		chk("oe off", el, 4'h0);
		hl.oe(1'b0);
		#2;
		chk("oe on", el, 4'hf);
		@(posedge core_clk);
		#1;
		done_t("oe");
		foreach (offs[i]) begin
			hl.op(offs[i], 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, adr_a, 36'h0);
			hl.idle();
			chk("power down", pl, 1'b1);
			chk("no drive", el, 4'h0);
		end
		done_t("power");
		fork
			hl.op(2'b10, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, adr_a, 36'h0a5a5a5a5);
			hr.op(2'b10, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 18'h03020, 36'h0);
		join
		fork
			hl.idle();
			hr.idle();
		join
		chk("left clash", kl, 1'b1);
		chk("right clash", kr, 1'b1);
		rd(1'b0, 1'b1, 1'b1, 4'h0, adr_a, d_one);
		done_t("conflict");
		wr(1'b0, 1'b1, 4'h0, 18'h05fff, d_thr);
		wr(1'b1, 1'b0, 4'h0, 18'h00000, d_fou);
		wr(1'b0, 1'b1, 4'h0, 18'h3ffff, d_thr);
		wr(1'b1, 1'b0, 4'h0, 18'h3ffff, d_fou);
		rd(1'b0, 1'b1, 1'b1, 4'h0, 18'h06000, d_fou);
		rd(1'b0, 1'b1, 1'b1, 4'h0, 18'h00000, d_fou);
		rd(1'b0, 1'b1, 1'b1, 4'h0, 18'h05fff, d_thr);
		rd(1'b1, 1'b0, 1'b1, 4'h0, 18'h3ffff, d_fou);
		rd(1'b1, 1'b1, 1'b1, 4'h0, 18'h3ffff, d_fou);
		rd(1'b1, 1'b1, 1'b0, 4'h0, 18'h00000, d_thr);
		hl.op(2'b10, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 18'h06000, 36'h0);
		rd(1'b1, 1'b1, 1'b0, 4'h0, 18'h00000, d_fou);
		done_t("counter");
		ce = 1'b0;
		wr(1'b0, 1'b1, 4'h0, adr_a, 36'h0a5a5a5a5);
		ce = 1'b1;
		hl.idle();
		rd(1'b0, 1'b1, 1'b1, 4'h0, adr_a, d_one);
		done_t("clock enable");
		close_out();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		close_out();
	end
endmodule
`default_nettype wire
